// >>> verilog/mie_core.sv
// What this block does
// (RULE_01) Writing the pc low byte adds one four-clock instruction cycle.
// (RULE_02) A taken skip adds one instruction cycle; untaken skip stays one cycle.
// (RULE_03) Increment or decrement skip to memory pays both extra cycles when it writes the pc low byte and skips.
// (RULE_04) Inc/dec skip to accumulator leaves memory, skips on zero result.
// (RULE_05) Skip-if-zero-to-acc copies the byte to accumulator, skips when zero.
// (RULE_06) Bit tests pick bit 0..7; one skips on zero, one on one.
// (RULE_07) Call takes two cycles, pushes next address, jumps, no flags.
// (RULE_08) Jump, return, return-immediate, return-from-irq take two cycles each.
// (RULE_09) Paged table read uses both pointers; low byte to memory, high byte latched.
// (RULE_10) Unpaged table read uses current page; last-page variant uses the top page.
// (RULE_11) Watchdog clear zeroes count, clears power-down and time-out, one cycle.
// (RULE_12) Two-step clear acts only after both pre-clear instructions ran.
// (RULE_13) Add-with-carry sums accumulator, byte and carry; updates four flags.
// (RULE_14) Add sums accumulator with byte or immediate; updates four flags.
// (RULE_15) AND writes accumulator or byte and updates only zero flag.
// (RULE_16) Clear-memory zeroes byte, clear-bit zeroes one bit, no flags.
// (RULE_17) Invert flips every bit of the byte and updates zero flag.
// (RULE_18) Nibble swap to memory or to accumulator, no flag changes.
// (RULE_19) Halt stops execution, clears watchdog, sets power-down, clears time-out.
// (RULE_20) Return-from-irq restores the counter and sets the global interrupt enable.
// (RULE_21) Set-memory writes all ones to the byte, no flags.
// (RULE_22) Overflow is signed overflow; auxiliary carry is carry out of bit 3.
`timescale 1ns/10ps
`include "mie_params.svh"

module mie_core #(
   parameter int PC_W = 13,
   parameter int DEPTH = 8
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_b_i,
   input  wire logic              issue_i,
   input  mie_pkg::mie_op_type    op_i,
   input  wire logic [7:0]        mem_data_i,
   input  wire logic [7:0]        mem_addr_i,
   input  wire logic [7:0]        imm_i,
   input  wire logic [2:0]        bit_sel_i,
   input  wire logic [PC_W-1:0]   target_i,
   input  wire logic              table_page_en_i,
   input  wire logic [7:0]        table_ptr_low_i,
   input  wire logic [7:0]        table_ptr_high_i,
   input  wire logic [15:0]       rom_word_i,
   input  wire logic              wake_i,
   output logic                   busy_o,
   output logic                   retire_o,
   output logic                   skip_o,
   output logic                   mem_we_o,
   output logic [7:0]             mem_addr_o,
   output logic [7:0]             mem_wdata_o,
   output logic [PC_W-1:0]        pc_o,
   output logic [PC_W-1:0]        rom_addr_o,
   output logic [7:0]             acc_o,
   output logic [7:0]             table_read_high_byte_o,
   output logic                   carry_flag_o,
   output logic                   zero_flag_o,
   output logic                   aux_carry_flag_o,
   output logic                   overflow_flag_o,
   output logic                   timeout_flag_o,
   output logic                   powerdown_flag_o,
   output logic                   global_irq_enable_o,
   output logic                   watchdog_clear_o,
   output logic                   halted_o
);
   import mie_pkg::*;

   mie_state_type         state_reg, state_next;
   logic [1:0]            phase_reg, phase_next;
   logic [1:0]            cyc_left_reg, cyc_left_next;
   logic                  busy_reg, busy_next;
   logic                  retire_reg, retire_next;
   logic                  skip_reg, skip_next;
   logic                  we_reg, we_next;
   logic [7:0]            maddr_reg, maddr_next;
   logic [7:0]            wdata_reg, wdata_next;
   logic [PC_W-1:0]       pc_reg, pc_next;
   logic [PC_W-1:0]       rom_addr_reg, rom_addr_next;
   logic [7:0]            acc_reg, acc_next;
   logic [7:0]            tbh_reg, tbh_next;
   logic                  c_reg, c_next, z_reg, z_next, ac_reg, ac_next, ov_reg, ov_next;
   logic                  to_reg, to_next, pd_reg, pd_next, emi_reg, emi_next;
   logic                  wdc_reg, wdc_next, pre_a_reg, pre_a_next, pre_b_reg, pre_b_next;
   logic                  halted_reg, halted_next;
   logic [PC_W-1:0]       stack_reg [DEPTH];
   logic [PC_W-1:0]       push_val;
   logic                  push, pop;
   logic [$clog2(DEPTH)-1:0] sp_reg, sp_next;
   logic [PC_W-1:0]       stack_top;

   assign stack_top = stack_reg[sp_reg - 1'b1];

   always_comb begin
      logic [8:0] sum;
      logic [4:0] lo;
      logic [7:0] addend, res, nib;
      logic       cin, do_skip, pcl_wr, res_wr, two;
      sum = '0;
      lo = '0;
      addend = mem_data_i;
      res = '0;
      nib = '0;
      cin = 1'b0;
      do_skip = 1'b0;
      pcl_wr = 1'b0;
      res_wr = 1'b0;
      two = 1'b0;
      state_next = state_reg;
      phase_next = phase_reg + 1'b1;
      cyc_left_next = cyc_left_reg;
      busy_next = busy_reg;
      retire_next = 1'b0;
      skip_next = 1'b0;
      we_next = 1'b0;
      maddr_next = maddr_reg;
      wdata_next = wdata_reg;
      pc_next = pc_reg;
      rom_addr_next = rom_addr_reg;
      acc_next = acc_reg;
      tbh_next = tbh_reg;
      c_next = c_reg;
      z_next = z_reg;
      ac_next = ac_reg;
      ov_next = ov_reg;
      to_next = to_reg;
      pd_next = pd_reg;
      emi_next = emi_reg;
      wdc_next = 1'b0;
      pre_a_next = pre_a_reg;
      pre_b_next = pre_b_reg;
      halted_next = halted_reg;
      push = 1'b0;
      pop = 1'b0;
      push_val = pc_reg + `MIE_PC_STEP;
      sp_next = sp_reg;
      case (state_reg)
         MIE_ST_IDLE: begin
            phase_next = '0;
            if (issue_i) begin
               busy_next = 1'b1;
               maddr_next = mem_addr_i;
               pc_next = pc_reg + `MIE_PC_STEP;
               cyc_left_next = `MIE_CYC_BASE;
               state_next = MIE_ST_EXEC;
               case (op_i)
                  MIE_OP_JMP: begin
                     pc_next = target_i;
                     two = 1'b1; // see (RULE_08)
                  end
                  MIE_OP_CALL: begin
                     push = 1'b1; // see (RULE_07)
                     pc_next = target_i;
                     two = 1'b1;
                  end
                  MIE_OP_RET, MIE_OP_RET_IMM, MIE_OP_RETURN_FROM_IRQ: begin
                     pop = 1'b1;
                     pc_next = stack_top;
                     two = 1'b1; // see (RULE_08)
                     if (op_i == MIE_OP_RET_IMM) acc_next = imm_i;
                     if (op_i == MIE_OP_RETURN_FROM_IRQ) emi_next = 1'b1; // see (RULE_20)
                  end
                  MIE_OP_SKIP_IF_ZERO: do_skip = (mem_data_i == `MIE_DATA_ZERO); // see (RULE_02)
                  MIE_OP_SKIP_IF_ZERO_TO_ACC: begin
                     acc_next = mem_data_i; // see (RULE_05)
                     do_skip = (mem_data_i == `MIE_DATA_ZERO);
                  end
                  MIE_OP_SKIP_IF_BIT_CLR: do_skip = ~mem_data_i[bit_sel_i]; // see (RULE_06)
                  MIE_OP_SKIP_IF_BIT_SET: do_skip = mem_data_i[bit_sel_i]; // see (RULE_06)
                  MIE_OP_INC_SKIP_IF_ZERO, MIE_OP_DEC_SKIP_IF_ZERO,
                  MIE_OP_INC_SKIP_ZERO_TO_ACC, MIE_OP_DEC_SKIP_ZERO_TO_ACC: begin
                     if (op_i == MIE_OP_INC_SKIP_IF_ZERO || op_i == MIE_OP_INC_SKIP_ZERO_TO_ACC)
                        res = mem_data_i + 8'h01;
                     else
                        res = mem_data_i - 8'h01;
                     do_skip = (res == `MIE_DATA_ZERO);
                     if (op_i == MIE_OP_INC_SKIP_IF_ZERO || op_i == MIE_OP_DEC_SKIP_IF_ZERO)
                        res_wr = 1'b1; // see (RULE_03)
                     else
                        acc_next = res; // see (RULE_04)
                  end
                  MIE_OP_TABLE_READ_INDEXED, MIE_OP_TABLE_READ_LAST_PAGE: begin
                     two = 1'b1;
                     if (op_i == MIE_OP_TABLE_READ_LAST_PAGE)
                        rom_addr_next = {{(PC_W-8){1'b1}}, table_ptr_low_i}; // see (RULE_10)
                     else if (table_page_en_i)
                        rom_addr_next = {table_ptr_high_i[PC_W-9:0], table_ptr_low_i}; // see (RULE_09)
                     else
                        rom_addr_next = {pc_reg[PC_W-1:8], table_ptr_low_i}; // see (RULE_10)
                  end
                  MIE_OP_CLR_MEM: begin
                     res = `MIE_DATA_ZERO; // see (RULE_16)
                     res_wr = 1'b1;
                  end
                  MIE_OP_SET_MEM: begin
                     res = `MIE_DATA_ONES; // see (RULE_21)
                     res_wr = 1'b1;
                  end
                  MIE_OP_CLR_BIT: begin
                     res = mem_data_i;
                     res[bit_sel_i] = 1'b0; // see (RULE_16)
                     res_wr = 1'b1;
                  end
                  MIE_OP_CLR_WDT: begin
                     wdc_next = 1'b1; // see (RULE_11)
                     to_next = 1'b0;
                     pd_next = 1'b0;
                  end
                  MIE_OP_WATCHDOG_PRECLEAR_A, MIE_OP_WATCHDOG_PRECLEAR_B: begin
                     if ((op_i == MIE_OP_WATCHDOG_PRECLEAR_A && pre_b_reg) ||
                         (op_i == MIE_OP_WATCHDOG_PRECLEAR_B && pre_a_reg)) begin
                        wdc_next = 1'b1; // see (RULE_12)
                        to_next = 1'b0;
                        pd_next = 1'b0;
                        pre_a_next = 1'b0;
                        pre_b_next = 1'b0;
                     end else if (op_i == MIE_OP_WATCHDOG_PRECLEAR_A) pre_a_next = 1'b1;
                     else pre_b_next = 1'b1;
                  end
                  MIE_OP_SWAP_MEM, MIE_OP_NIBBLE_SWAP_TO_ACC: begin
                     nib = {mem_data_i[`MIE_NIB_LO_MSB:0], mem_data_i[7:`MIE_NIB_LO_MSB+1]}; // see (RULE_18)
                     res = nib;
                     res_wr = (op_i == MIE_OP_SWAP_MEM);
                     if (!res_wr) acc_next = nib;
                  end
                  MIE_OP_HALT: begin
                     wdc_next = 1'b1; // see (RULE_19)
                     pd_next = 1'b1;
                     to_next = 1'b0;
                     halted_next = 1'b1;
                  end
                  MIE_OP_ADD_ACC, MIE_OP_ADD_TO_MEM, MIE_OP_ADD_CARRY_ACC, MIE_OP_ADD_CARRY_TO_MEM: begin
                     // Immediate form reuses the accumulator opcode with imm_i as addend
                     if (op_i == MIE_OP_ADD_ACC && mem_addr_i == `MIE_DATA_ZERO && imm_i != `MIE_DATA_ZERO)
                        addend = imm_i;
                     cin = (op_i == MIE_OP_ADD_CARRY_ACC || op_i == MIE_OP_ADD_CARRY_TO_MEM) & c_reg; // see (RULE_13)
                     sum = {1'b0, acc_reg} + {1'b0, addend} + {8'h00, cin}; // see (RULE_14)
                     lo = {1'b0, acc_reg[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
                     res = sum[7:0];
                     c_next = sum[8];
                     z_next = (res == `MIE_DATA_ZERO);
                     ac_next = lo[4]; // see (RULE_22)
                     ov_next = (acc_reg[`MIE_SIGN_BIT] == addend[`MIE_SIGN_BIT]) &&
                               (res[`MIE_SIGN_BIT] != acc_reg[`MIE_SIGN_BIT]); // see (RULE_22)
                     if (op_i == MIE_OP_ADD_TO_MEM || op_i == MIE_OP_ADD_CARRY_TO_MEM) res_wr = 1'b1;
                     else acc_next = res;
                  end
                  MIE_OP_BITAND_ACC, MIE_OP_BITAND_TO_MEM: begin
                     res = acc_reg & ((op_i == MIE_OP_BITAND_ACC && mem_addr_i == `MIE_DATA_ZERO) ?
                                      imm_i : mem_data_i);
                     z_next = (res == `MIE_DATA_ZERO); // see (RULE_15)
                     if (op_i == MIE_OP_BITAND_TO_MEM) res_wr = 1'b1;
                     else acc_next = res;
                  end
                  MIE_OP_INVERT_BYTE: begin
                     res = ~mem_data_i; // see (RULE_17)
                     z_next = (res == `MIE_DATA_ZERO);
                     res_wr = 1'b1;
                  end
                  default: ;
               endcase
               if (res_wr) begin
                  we_next = 1'b1;
                  wdata_next = res;
                  pcl_wr = (mem_addr_i == `MIE_PCL_ADDR);
               end
               if (two) cyc_left_next = `MIE_CYC_TWO;
               cyc_left_next = cyc_left_next + {1'b0, pcl_wr} + {1'b0, do_skip}; // see (RULE_01)
               if (do_skip) pc_next = pc_next + `MIE_PC_STEP;
               if (pcl_wr) pc_next = {pc_reg[PC_W-1:8], res};
               skip_next = do_skip;
               if (push) sp_next = sp_reg + 1'b1;
               if (pop) sp_next = sp_reg - 1'b1;
            end
         end
         MIE_ST_EXEC: begin
            if (phase_reg == `MIE_PHASE_LAST) begin
               cyc_left_next = cyc_left_reg - 1'b1;
               if (cyc_left_reg == `MIE_CYC_BASE) begin
                  retire_next = 1'b1;
                  if (op_i == MIE_OP_TABLE_READ_INDEXED || op_i == MIE_OP_TABLE_READ_LAST_PAGE) begin
                     we_next = 1'b1;
                     wdata_next = rom_word_i[7:0];
                     tbh_next = rom_word_i[15:8];
                  end
                  if (halted_reg) begin
                     state_next = MIE_ST_HALTED;
                  end else begin
                     busy_next = 1'b0;
                     state_next = MIE_ST_IDLE;
                  end
               end
            end
         end
         MIE_ST_HALTED: begin
            phase_next = '0;
            if (wake_i) begin
               halted_next = 1'b0;
               busy_next = 1'b0;
               state_next = MIE_ST_IDLE;
            end
         end
         default: state_next = MIE_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state_reg <= MIE_ST_IDLE;
         phase_reg <= '0;
         cyc_left_reg <= '0;
         busy_reg <= 1'b0;
         retire_reg <= 1'b0;
         skip_reg <= 1'b0;
         we_reg <= 1'b0;
         maddr_reg <= '0;
         wdata_reg <= '0;
         pc_reg <= `MIE_PC_RESET;
         rom_addr_reg <= '0;
         acc_reg <= '0;
         tbh_reg <= '0;
         {c_reg, z_reg, ac_reg, ov_reg} <= '0;
         {to_reg, pd_reg, emi_reg} <= '0;
         {wdc_reg, pre_a_reg, pre_b_reg, halted_reg} <= '0;
         sp_reg <= '0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         cyc_left_reg <= cyc_left_next;
         busy_reg <= busy_next;
         retire_reg <= retire_next;
         skip_reg <= skip_next;
         we_reg <= we_next;
         maddr_reg <= maddr_next;
         wdata_reg <= wdata_next;
         pc_reg <= pc_next;
         rom_addr_reg <= rom_addr_next;
         acc_reg <= acc_next;
         tbh_reg <= tbh_next;
         {c_reg, z_reg, ac_reg, ov_reg} <= {c_next, z_next, ac_next, ov_next};
         {to_reg, pd_reg, emi_reg} <= {to_next, pd_next, emi_next};
         {wdc_reg, pre_a_reg, pre_b_reg, halted_reg} <= {wdc_next, pre_a_next, pre_b_next, halted_next};
         sp_reg <= sp_next;
      end
   end

   // Stack contents need no reset; only the pointer is control state
   always_ff @(posedge clk_sys_i) begin
      if (push) stack_reg[sp_reg] <= push_val;
   end

   assign busy_o = busy_reg;
   assign retire_o = retire_reg;
   assign skip_o = skip_reg;
   assign mem_we_o = we_reg;
   assign mem_addr_o = maddr_reg;
   assign mem_wdata_o = wdata_reg;
   assign pc_o = pc_reg;
   assign rom_addr_o = rom_addr_reg;
   assign acc_o = acc_reg;
   assign table_read_high_byte_o = tbh_reg;
   assign carry_flag_o = c_reg;
   assign zero_flag_o = z_reg;
   assign aux_carry_flag_o = ac_reg;
   assign overflow_flag_o = ov_reg;
   assign timeout_flag_o = to_reg;
   assign powerdown_flag_o = pd_reg;
   assign global_irq_enable_o = emi_reg;
   assign watchdog_clear_o = wdc_reg;
   assign halted_o = halted_reg;
endmodule : mie_core

// >>> verilog/mie_params.svh
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH
`define MIE_CLK_PER_ICYC       3'd4
`define MIE_PHASE_LAST         2'd3
`define MIE_DATA_ZERO          8'h00
`define MIE_DATA_ONES          8'hFF
`define MIE_WDT_ZERO           8'h00
`define MIE_PC_STEP            13'h0001
`define MIE_PC_RESET           13'h0000
`define MIE_CYC_BASE           2'd1
`define MIE_CYC_TWO            2'd2
`define MIE_PCL_ADDR           8'h06
`define MIE_NIB_LO_MSB         3
`define MIE_SIGN_BIT           7
`endif

// >>> verilog/mie_pkg.sv
package mie_pkg;
   typedef enum logic [4:0] {
      MIE_OP_NOP, MIE_OP_JMP, MIE_OP_SKIP_IF_ZERO, MIE_OP_SKIP_IF_ZERO_TO_ACC,
      MIE_OP_SKIP_IF_BIT_CLR, MIE_OP_SKIP_IF_BIT_SET, MIE_OP_INC_SKIP_IF_ZERO,
      MIE_OP_DEC_SKIP_IF_ZERO, MIE_OP_INC_SKIP_ZERO_TO_ACC, MIE_OP_DEC_SKIP_ZERO_TO_ACC,
      MIE_OP_CALL, MIE_OP_RET, MIE_OP_RET_IMM, MIE_OP_RETURN_FROM_IRQ,
      MIE_OP_TABLE_READ_INDEXED, MIE_OP_TABLE_READ_LAST_PAGE, MIE_OP_CLR_MEM, MIE_OP_SET_MEM,
      MIE_OP_CLR_WDT, MIE_OP_WATCHDOG_PRECLEAR_A, MIE_OP_WATCHDOG_PRECLEAR_B, MIE_OP_SWAP_MEM,
      MIE_OP_NIBBLE_SWAP_TO_ACC, MIE_OP_HALT, MIE_OP_ADD_ACC, MIE_OP_ADD_TO_MEM,
      MIE_OP_ADD_CARRY_ACC, MIE_OP_ADD_CARRY_TO_MEM, MIE_OP_BITAND_ACC, MIE_OP_BITAND_TO_MEM,
      MIE_OP_CLR_BIT, MIE_OP_INVERT_BYTE
   } mie_op_type;

   typedef enum {
      MIE_ST_IDLE, MIE_ST_EXEC, MIE_ST_HALTED
   } mie_state_type;
endpackage : mie_pkg

// >>> dv/mie_core_sva.sv
`timescale 1ns/10ps
module mie_core_sva
   import mie_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   input wire logic        issue_i,
   input mie_op_type       op_i,
   input wire logic [7:0]  mem_data_i,
   input wire logic [7:0]  mem_addr_i,
   input wire logic        busy_o,
   input wire logic        retire_o,
   input wire logic        skip_o,
   input wire logic        mem_we_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic [7:0]  acc_o,
   input wire logic        carry_flag_o,
   input wire logic        zero_flag_o,
   input wire logic        timeout_flag_o,
   input wire logic        powerdown_flag_o,
   input wire logic        global_irq_enable_o,
   input wire logic        watchdog_clear_o
);
   logic       take;
   logic [7:0] swapped;
   assign take = issue_i && !busy_o;
   assign swapped = {mem_data_i[3:0], mem_data_i[7:4]};
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   property p_two_cyc;
      take && op_i inside {MIE_OP_JMP, MIE_OP_CALL, MIE_OP_RET, MIE_OP_RET_IMM, MIE_OP_RETURN_FROM_IRQ}
         |-> ##1 (busy_o && !retire_o) [*8] ##1 retire_o;
   endproperty
   a_two_cyc: assert property (p_two_cyc) else $error("branch op not eight clocks");
   property p_one_cyc;
      take && op_i inside {MIE_OP_CLR_WDT, MIE_OP_NIBBLE_SWAP_TO_ACC} |-> ##1 (busy_o && !retire_o) [*4] ##1 retire_o;
   endproperty
   a_one_cyc: assert property (p_one_cyc) else $error("one-cycle op not four clocks");
   property p_skip_taken;
      take && op_i == MIE_OP_SKIP_IF_ZERO && mem_data_i == 8'h00 |-> ##1 skip_o ##8 retire_o;
   endproperty
   a_skip_taken: assert property (p_skip_taken) else $error("taken skip timing wrong");
   property p_skip_not;
      take && op_i == MIE_OP_SKIP_IF_ZERO && mem_data_i != 8'h00 |-> ##1 !skip_o ##4 retire_o;
   endproperty
   a_skip_not: assert property (p_skip_not) else $error("untaken skip timing wrong");
   property p_both_cost;
      take && op_i == MIE_OP_INC_SKIP_IF_ZERO && mem_addr_i == 8'h06 && mem_data_i == 8'hFF
         |-> ##1 (mem_we_o && mem_wdata_o == 8'h00) ##12 retire_o;
   endproperty
   a_both_cost: assert property (p_both_cost) else $error("pc low skip not twelve clocks");
   property p_clr_mem;
      take && op_i == MIE_OP_CLR_MEM
         |-> ##1 mem_we_o && mem_wdata_o == 8'h00 && $stable(zero_flag_o) && $stable(carry_flag_o);
   endproperty
   a_clr_mem: assert property (p_clr_mem) else $error("clear memory wrong");
   property p_set_mem;
      take && op_i == MIE_OP_SET_MEM |-> ##1 mem_we_o && mem_wdata_o == 8'hFF && $stable(zero_flag_o);
   endproperty
   a_set_mem: assert property (p_set_mem) else $error("set memory wrong");
   property p_invert;
      take && op_i == MIE_OP_INVERT_BYTE
         |-> ##1 mem_we_o && mem_wdata_o == ~$past(mem_data_i) && zero_flag_o == (mem_wdata_o == 8'h00);
   endproperty
   a_invert: assert property (p_invert) else $error("invert wrong");
   property p_swap_acc;
      take && op_i == MIE_OP_NIBBLE_SWAP_TO_ACC |-> ##1 !mem_we_o && acc_o == $past(swapped);
   endproperty
   a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");
   property p_clr_wdt;
      take && op_i == MIE_OP_CLR_WDT |-> ##1 watchdog_clear_o && !powerdown_flag_o && !timeout_flag_o;
   endproperty
   a_clr_wdt: assert property (p_clr_wdt) else $error("watchdog clear wrong");
   property p_return_from_irq;
      take && op_i == MIE_OP_RETURN_FROM_IRQ |-> ##[1:8] global_irq_enable_o;
   endproperty
   a_return_from_irq: assert property (p_return_from_irq) else $error("irq return left enable low");
   property p_halt;
      take && op_i == MIE_OP_HALT |-> ##[1:4] powerdown_flag_o && !timeout_flag_o;
   endproperty
   a_halt: assert property (p_halt) else $error("halt flags wrong");
endmodule : mie_core_sva

bind mie_core mie_core_sva i_mie_core_sva (.*);

// >>> dv/mie_core_bench.sv
`timescale 1ns/10ps
module mie_core_bench;
   import mie_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        issue_i = 1'b0;
   logic        table_page_en_i = 1'b0;
   logic        wake_i = 1'b0;
   mie_op_type  op_i = MIE_OP_NOP;
   logic [7:0]  mem_data_i = '0, mem_addr_i = '0, imm_i = '0;
   logic [7:0]  table_ptr_low_i = '0, table_ptr_high_i = '0;
   logic [2:0]  bit_sel_i = '0;
   logic [12:0] target_i = '0, pc_o, rom_addr_o, ra;
   logic [15:0] rom_word_i = '0;
   logic        busy_o, retire_o, skip_o, mem_we_o, carry_flag_o, zero_flag_o, aux_carry_flag_o, overflow_flag_o;
   logic        timeout_flag_o, powerdown_flag_o, global_irq_enable_o, watchdog_clear_o, halted_o, sk, we, wdc;
   logic [7:0]  mem_addr_o, mem_wdata_o, acc_o, table_read_high_byte_o, wd;
   logic [3:0]  flg;
   int          fail_count = 0, checks = 0, cycles = 0, n = 0;

   assign flg = {overflow_flag_o, aux_carry_flag_o, carry_flag_o, zero_flag_o};

   mie_core i_mie_core (.clk_sys_i, .rst_b_i, .issue_i, .op_i, .mem_data_i, .mem_addr_i, .imm_i, .bit_sel_i,
      .target_i, .table_page_en_i, .table_ptr_low_i, .table_ptr_high_i, .rom_word_i, .wake_i, .busy_o, .retire_o,
      .skip_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .pc_o, .rom_addr_o, .acc_o, .table_read_high_byte_o,
      .carry_flag_o, .zero_flag_o, .aux_carry_flag_o, .overflow_flag_o, .timeout_flag_o, .powerdown_flag_o,
      .global_irq_enable_o, .watchdog_clear_o, .halted_o);

   always #2 clk_sys_i = ~clk_sys_i;

   task conclude;
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // ~60 instructions, twelve clocks at most
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         $display("[FAIL] %0t run hung", $time);
         conclude();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // x feeds immediate, bit index and target; each op reads its own
   task run(input mie_op_type op, input logic [7:0] a, input logic [7:0] d, input logic [15:0] x, input int ic);
      @(posedge clk_sys_i);
      op_i <= op;
      mem_addr_i <= a;
      mem_data_i <= d;
      imm_i <= x[7:0];
      bit_sel_i <= x[2:0];
      target_i <= x[12:0];
      issue_i <= 1'b1;
      @(posedge clk_sys_i);
      issue_i <= 1'b0;
      // Skip, write and watchdog pulses stand in the cycle after the issue edge; table-read writes come at retire
      #1;
      sk = skip_o;
      {we, wd, ra} = {mem_we_o, mem_wdata_o, rom_addr_o};
      wdc = watchdog_clear_o;
      for (n = 0; !retire_o && n < 40; n++) begin
         @(posedge clk_sys_i);
         #1;
         if (mem_we_o) {we, wd, ra} = {1'b1, mem_wdata_o, rom_addr_o};
         wdc = wdc | watchdog_clear_o;
      end
      chk(n, 4 * ic);
   endtask : run

   task halt_wake;
      run(MIE_OP_HALT, '0, '0, '0, 1);
      chk({halted_o, powerdown_flag_o, timeout_flag_o}, 3'b110);
      @(posedge clk_sys_i);
      wake_i <= 1'b1;
      @(posedge clk_sys_i);
      wake_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk(halted_o, 1'b0);
   endtask : halt_wake

   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      run(MIE_OP_RET_IMM, '0, '0, 16'h007F, 2); chk(acc_o, 8'h7F);
      run(MIE_OP_ADD_ACC, '0, '0, 16'h0001, 1); chk({acc_o, flg}, {8'h80, 4'b1100});
      run(MIE_OP_ADD_CARRY_TO_MEM, 8'h20, 8'h80, '0, 1);
      chk({we, wd, acc_o, flg}, {1'b1, 8'h00, 8'h80, 4'b1011});
      run(MIE_OP_BITAND_ACC, 8'h20, 8'hC0, '0, 1); chk({acc_o, flg}, {8'h80, 4'b1010});
      run(MIE_OP_ADD_CARRY_ACC, 8'h20, 8'h00, '0, 1); chk({acc_o, flg}, {8'h81, 4'b0000});
      run(MIE_OP_ADD_TO_MEM, 8'h06, 8'h01, '0, 2); chk({we, wd, flg}, {1'b1, 8'h82, 4'b0000});
      run(MIE_OP_BITAND_TO_MEM, 8'h21, 8'h01, '0, 1); chk({we, wd, acc_o, flg}, {9'h101, 8'h81, 4'h0});
      run(MIE_OP_INVERT_BYTE, 8'h21, 8'hFF, '0, 1); chk({we, wd, flg}, {9'h100, 4'b0001});
      run(MIE_OP_CLR_MEM, 8'h21, 8'h5A, '0, 1); chk({we, wd, flg}, {9'h100, 4'b0001});
      run(MIE_OP_SET_MEM, 8'h21, 8'h00, '0, 1); chk({we, wd, flg}, {9'h1FF, 4'b0001});
      run(MIE_OP_CLR_BIT, 8'h21, 8'hFF, 16'h0003, 1); chk({we, wd, flg}, {9'h1F7, 4'b0001});
      run(MIE_OP_SWAP_MEM, 8'h21, 8'h3C, '0, 1); chk({we, wd}, 9'h1C3);
      run(MIE_OP_NIBBLE_SWAP_TO_ACC, 8'h21, 8'hA5, '0, 1); chk({we, acc_o, flg}, {9'h05A, 4'b0001});
      run(MIE_OP_CLR_MEM, 8'h06, 8'h11, '0, 2); chk({we, wd}, 9'h100);
      for (int b = 0; b < 8; b++) begin
         run(MIE_OP_SKIP_IF_BIT_CLR, 8'h21, ~(8'h01 << b), 16'(b), 2); chk({sk, flg}, 5'b10001);
         run(MIE_OP_SKIP_IF_BIT_SET, 8'h21, ~(8'h01 << b), 16'(b), 1); chk(sk, 1'b0);
         run(MIE_OP_SKIP_IF_BIT_SET, 8'h21, 8'h01 << b, 16'(b), 2); chk(sk, 1'b1);
      end
      run(MIE_OP_SKIP_IF_ZERO, 8'h21, 8'h00, '0, 2); chk({sk, we}, 2'b10);
      run(MIE_OP_SKIP_IF_ZERO, 8'h21, 8'h01, '0, 1); chk(sk, 1'b0);
      run(MIE_OP_SKIP_IF_ZERO_TO_ACC, 8'h21, 8'h00, '0, 2); chk({sk, acc_o}, 9'h100);
      run(MIE_OP_SKIP_IF_ZERO_TO_ACC, 8'h21, 8'h3C, '0, 1); chk({sk, acc_o, flg}, {9'h03C, 4'h1});
      run(MIE_OP_INC_SKIP_IF_ZERO, 8'h21, 8'hFF, '0, 2); chk({sk, we, wd}, 10'h300);
      run(MIE_OP_INC_SKIP_IF_ZERO, 8'h06, 8'hFF, '0, 3); chk({sk, we, wd}, 10'h300);
      run(MIE_OP_DEC_SKIP_IF_ZERO, 8'h21, 8'h05, '0, 1); chk({sk, we, wd}, 10'h104);
      run(MIE_OP_INC_SKIP_ZERO_TO_ACC, 8'h21, 8'hFF, '0, 2); chk({sk, we, acc_o}, 10'h200);
      run(MIE_OP_DEC_SKIP_ZERO_TO_ACC, 8'h21, 8'h03, '0, 1); chk({sk, we, acc_o}, 10'h002);
      run(MIE_OP_JMP, '0, '0, 16'h0100, 2); chk(pc_o, 13'h0100);
      run(MIE_OP_CALL, '0, '0, 16'h0ABC, 2); chk({pc_o, flg}, {13'h0ABC, 4'h1});
      run(MIE_OP_RET, '0, '0, '0, 2); chk(pc_o, 13'h0101);
      run(MIE_OP_CALL, '0, '0, 16'h1555, 2); chk(pc_o, 13'h1555);
      run(MIE_OP_RETURN_FROM_IRQ, '0, '0, '0, 2); chk({global_irq_enable_o, pc_o}, 14'h2102);
      @(posedge clk_sys_i);
      table_page_en_i <= 1'b1;
      table_ptr_low_i <= 8'h34;
      table_ptr_high_i <= 8'h12;
      rom_word_i <= 16'hBEEF;
      run(MIE_OP_TABLE_READ_INDEXED, 8'h22, '0, '0, 2);
      chk({we, wd, table_read_high_byte_o, ra}, {9'h1EF, 8'hBE, 13'h1234});
      @(posedge clk_sys_i);
      table_page_en_i <= 1'b0;
      rom_word_i <= 16'hA55A;
      run(MIE_OP_TABLE_READ_INDEXED, 8'h22, '0, '0, 2);
      chk({we, wd, table_read_high_byte_o, ra[7:0]}, {9'h15A, 8'hA5, 8'h34});
      run(MIE_OP_TABLE_READ_LAST_PAGE, 8'h22, '0, '0, 2); chk({we, ra}, {1'b1, 13'h1F34});
      halt_wake();
      run(MIE_OP_CLR_WDT, '0, '0, '0, 1); chk({wdc, powerdown_flag_o, timeout_flag_o}, 3'b100);
      halt_wake();
      run(MIE_OP_WATCHDOG_PRECLEAR_A, '0, '0, '0, 1); chk({wdc, powerdown_flag_o}, 2'b01);
      run(MIE_OP_WATCHDOG_PRECLEAR_A, '0, '0, '0, 1); chk({wdc, powerdown_flag_o}, 2'b01);
      run(MIE_OP_WATCHDOG_PRECLEAR_B, '0, '0, '0, 1); chk({wdc, powerdown_flag_o}, 2'b10);
      conclude();
   end
endmodule : mie_core_bench
